// ---- hdl/duc_top.sv ----
// Purpose: Control registers, update scheduling and reference enables for DAC channel 1.
// Assumes: Special function register strobes come from the core on ref_clk.
// Notes: Latch transfer lands one cycle after its trigger.
`timescale 1ns/100ps
module duc_top
  import duc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire duc_sfr_s sfr,
  input wire duc_tmr_s tmr,
  output logic [7:0] sfr_rdata,
  output logic [11:0] dac_latch,
  output logic dac_enable,
  output logic dac_out_en,
  output logic bias_on,
  output logic ref_buf_on,
  output logic ref_pin_oe,
  output logic temp_on,
  output logic temp_mux_sel,
  output logic latch_strobe
);

  // ==========================================================================
  // Register decode
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] lo_r, lo_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic [7:0] refc_r, refc_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [11:0] latch_r, latch_nxt;
  logic strobe_r, strobe_nxt;
  logic [11:0] word_cur;
  logic [11:0] word_wr;
  logic wr_ctrl, wr_lo, wr_hi, wr_ref;
  logic trig;

  function automatic logic hit(input duc_sfr_s s, input logic [7:0] a, input logic [7:0] p);
    hit = (s.addr == a) && (s.page == p);
  endfunction : hit

  assign wr_ctrl = sfr.wr && hit(sfr, DUC_ADDR_CONTROL, DUC_PAGE_DAC1);
  assign wr_lo = sfr.wr && hit(sfr, DUC_ADDR_DATA_LOW, DUC_PAGE_DAC1);
  assign wr_hi = sfr.wr && hit(sfr, DUC_ADDR_DATA_HIGH, DUC_PAGE_DAC1);
  assign wr_ref = sfr.wr && hit(sfr, DUC_ADDR_REFERENCE, DUC_PAGE_REF);

  // Format of the stored bytes, used for timer-driven transfers.
  duc_format u_fmt_cur (
    .fmt(ctrl_r[DUC_FMT_LSB +: 3]),
    .hi(hi_r),
    .lo(lo_r),
    .word(word_cur)
  );

  // Format including the high byte being written this cycle.
  duc_format u_fmt_wr (
    .fmt(ctrl_r[DUC_FMT_LSB +: 3]),
    .hi(sfr.wdata),
    .lo(lo_r),
    .word(word_wr)
  );

  // ==========================================================================
  // Trigger selection
  always_comb begin
    case (ctrl_r[DUC_MODE_LSB +: 2])
      DUC_MODE_WRITE: trig = wr_hi;
      DUC_MODE_T3: trig = tmr.t3;
      DUC_MODE_T4: trig = tmr.t4;
      DUC_MODE_T2: trig = tmr.t2;
      default: trig = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    ctrl_nxt = ctrl_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    refc_nxt = refc_r;
    latch_nxt = latch_r;
    strobe_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (wr_ctrl) begin
      ctrl_nxt = sfr.wdata & DUC_CONTROL_WMASK;
    end
    if (wr_lo) begin
      lo_nxt = sfr.wdata;
    end
    if (wr_hi) begin
      hi_nxt = sfr.wdata;
    end
    if (wr_ref) begin
      refc_nxt = sfr.wdata & DUC_REFERENCE_WMASK;
    end
    // A high-byte write in write mode uses the fresh byte so the output tracks it at once.
    if (trig) begin
      strobe_nxt = 1'b1;
      if (ctrl_r[DUC_MODE_LSB +: 2] == DUC_MODE_WRITE) begin
        latch_nxt = word_wr;
      end else begin
        latch_nxt = word_cur;
      end
    end
    if (sfr.rd) begin
      if (hit(sfr, DUC_ADDR_CONTROL, DUC_PAGE_DAC1)) begin
        rdata_nxt = ctrl_r & DUC_CONTROL_WMASK;
      end else if (hit(sfr, DUC_ADDR_DATA_LOW, DUC_PAGE_DAC1)) begin
        rdata_nxt = lo_r;
      end else if (hit(sfr, DUC_ADDR_DATA_HIGH, DUC_PAGE_DAC1)) begin
        rdata_nxt = hi_r;
      end else if (hit(sfr, DUC_ADDR_REFERENCE, DUC_PAGE_REF)) begin
        rdata_nxt = refc_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= DUC_CONTROL_RST;
      lo_r <= DUC_DATA_RST;
      hi_r <= DUC_DATA_RST;
      refc_r <= DUC_REFERENCE_RST;
      latch_r <= DUC_LATCH_RST;
      strobe_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      refc_r <= refc_nxt;
      latch_r <= latch_nxt;
      strobe_r <= strobe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Analog enables from four flops; each paired output shares its partner's flop
  logic en_r, en_nxt, bias_r, bias_nxt, buf_r, buf_nxt, temp_r, temp_nxt;

  always_comb begin
    en_nxt = ctrl_nxt[DUC_EN_BIT];
    bias_nxt = refc_nxt[DUC_BIAS_BIT];
    buf_nxt = refc_nxt[DUC_BUF_BIT];
    temp_nxt = refc_nxt[DUC_TEMP_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      bias_r <= 1'b0;
      buf_r <= 1'b0;
      temp_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      bias_r <= bias_nxt;
      buf_r <= buf_nxt;
      temp_r <= temp_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign dac_latch = latch_r;
  assign latch_strobe = strobe_r;
  assign dac_enable = en_r;
  assign dac_out_en = en_r;
  assign bias_on = bias_r;
  assign ref_buf_on = buf_r;
  assign ref_pin_oe = buf_r;
  assign temp_on = temp_r;
  assign temp_mux_sel = temp_r;

endmodule : duc_top

// ---- inc/duc_pkg.sv ----
// Purpose: Shared constants and carriers for the DAC channel 1 update and reference control.
// Assumes: Byte-wide special function register access on one 10 MHz clock.
// Notes: Timer overflow inputs arrive as single-cycle pulses from logic on the same clock.
package duc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] DUC_ADDR_CONTROL = 8'hD4;
  localparam logic [7:0] DUC_ADDR_DATA_LOW = 8'hD5;
  localparam logic [7:0] DUC_ADDR_DATA_HIGH = 8'hD6;
  localparam logic [7:0] DUC_ADDR_REFERENCE = 8'hD1;
  localparam logic [7:0] DUC_PAGE_DAC1 = 8'h01;
  localparam logic [7:0] DUC_PAGE_REF = 8'h00;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [7:0] DUC_CONTROL_RST = 8'h00;
  localparam logic [7:0] DUC_DATA_RST = 8'h00;
  localparam logic [7:0] DUC_REFERENCE_RST = 8'h00;
  localparam logic [11:0] DUC_LATCH_RST = 12'h000;
  localparam int DUC_EN_BIT = 7;
  localparam int DUC_MODE_LSB = 3;
  localparam int DUC_FMT_LSB = 0;
  localparam int DUC_TEMP_BIT = 2;
  localparam int DUC_BIAS_BIT = 1;
  localparam int DUC_BUF_BIT = 0;
  localparam logic [7:0] DUC_CONTROL_WMASK = 8'h9F;
  localparam logic [7:0] DUC_REFERENCE_WMASK = 8'h1F;

  // ==========================================================================
  // Update modes
  localparam logic [1:0] DUC_MODE_WRITE = 2'h0;
  localparam logic [1:0] DUC_MODE_T3 = 2'h1;
  localparam logic [1:0] DUC_MODE_T4 = 2'h2;
  localparam logic [1:0] DUC_MODE_T2 = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } duc_sfr_s;

  typedef struct packed {
    logic t2;
    logic t3;
    logic t4;
  } duc_tmr_s;

endpackage : duc_pkg

// ---- hdl/duc_format.sv ----
// Purpose: Justifies the 12-bit converter word out of the high and low data bytes.
// Assumes: Format field is the low three bits of the control register.
// Notes: Purely combinational.
`timescale 1ns/100ps
module duc_format
  import duc_pkg::*;
(
  input wire logic [2:0] fmt,
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  output logic [11:0] word
);

  always_comb begin
    if (fmt[2]) begin
      word = {hi, lo[7:4]};
    end else begin
      case (fmt[1:0])
        2'h0: word = {hi[3:0], lo};
        2'h1: word = {hi[4:0], lo[7:1]};
        2'h2: word = {hi[5:0], lo[7:2]};
        2'h3: word = {hi[6:0], lo[7:3]};
        default: word = {hi[3:0], lo};
      endcase
    end
  end

endmodule : duc_format

// ---- tb/duc_chk.sv ----
// Purpose: Port assertions for duc_top.
// Assumes: Update mode is shadowed from control writes.
// Notes: Timer pulses last one cycle.
`timescale 1ns/100ps
module duc_chk
  import duc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire duc_sfr_s sfr,
  input wire duc_tmr_s tmr,
  input wire logic [7:0] sfr_rdata,
  input wire logic [11:0] dac_latch,
  input wire logic dac_enable,
  input wire logic dac_out_en,
  input wire logic bias_on,
  input wire logic ref_buf_on,
  input wire logic ref_pin_oe,
  input wire logic temp_on,
  input wire logic temp_mux_sel,
  input wire logic latch_strobe
);
  // ==========
  // Helpers
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] md_r;
  wire p1 = sfr.page == 8'h01;
  wire wc = sfr.wr && p1 && sfr.addr == 8'hD4;
  wire wh = sfr.wr && p1 && sfr.addr == 8'hD6;
  wire hit = (wh && md_r == 2'h0) || (tmr.t3 && md_r == 2'h1) ||
    (tmr.t4 && md_r == 2'h2) || (tmr.t2 && md_r == 2'h3);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) md_r <= 2'h0;
    else if (wc) md_r <= sfr.wdata[4:3];
  end
  // ==========
  // Properties
  property p_en; wc |=> dac_enable == $past(sfr.wdata[7]) && dac_out_en == dac_enable; endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_rsv; sfr.rd && p1 && sfr.addr == 8'hD4 |=> sfr_rdata[6:5] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("unused bits");
  property p_m0; wh && md_r == 2'h0 |=> latch_strobe; endproperty
  a_m0: assert property (p_m0) else $error("high write");
  property p_t3; tmr.t3 && md_r == 2'h1 |=> latch_strobe; endproperty
  a_t3: assert property (p_t3) else $error("timer 3");
  property p_t4; tmr.t4 && md_r == 2'h2 |=> latch_strobe; endproperty
  a_t4: assert property (p_t4) else $error("timer 4");
  property p_t2; tmr.t2 && md_r == 2'h3 |=> latch_strobe; endproperty
  a_t2: assert property (p_t2) else $error("timer 2");
  property p_hold; !hit |=> !latch_strobe && $stable(dac_latch); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_ref; sfr.wr && sfr.page == 8'h00 && sfr.addr == 8'hD1 |=>
    {temp_on, bias_on, ref_buf_on} == $past(sfr.wdata[2:0]) &&
    ref_pin_oe == ref_buf_on && temp_mux_sel == temp_on; endproperty
  a_ref: assert property (p_ref) else $error("reference");
endmodule : duc_chk

bind duc_top duc_chk u_chk (.ref_clk, .rst_n, .sfr, .tmr, .sfr_rdata, .dac_latch,
  .dac_enable, .dac_out_en, .bias_on, .ref_buf_on, .ref_pin_oe, .temp_on,
  .temp_mux_sel, .latch_strobe);

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for duc_top.
// Assumes: One access every two cycles.
// Notes: Expected words come from the bench's own format table.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t got %h exp %h", $time, (a), (b)); end end
module tb_top
  import duc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  duc_sfr_s sfr = '0;
  duc_tmr_s tmr = '0;
  logic [7:0] sfr_rdata, r, lo, hi;
  logic [11:0] dac_latch, ex;
  logic [2:0] msk;
  logic dac_enable, dac_out_en, bias_on, ref_buf_on, ref_pin_oe, temp_on, temp_mux_sel;
  logic latch_strobe;
  int n_fail = 0, n_checks = 0, cyc = 0;
  duc_top u_dut (.ref_clk, .rst_n, .sfr, .tmr, .sfr_rdata, .dac_latch, .dac_enable,
    .dac_out_en, .bias_on, .ref_buf_on, .ref_pin_oe, .temp_on, .temp_mux_sel, .latch_strobe);
  // ==========
  // Tasks
  task automatic ax(input logic w, input logic [7:0] a, p, d);
    @(posedge ref_clk);
    sfr <= '{wr: w, rd: !w, addr: a, page: p, wdata: d};
    @(posedge ref_clk);
    sfr <= '0;
    #1;
  endtask : ax
  task automatic tp(input logic [2:0] v);
    @(posedge ref_clk);
    tmr <= v;
    @(posedge ref_clk);
    tmr <= '0;
    #1;
  endtask : tp
  task automatic lat(input logic s);
    `CHK(latch_strobe, s)
    `CHK(dac_latch, ex)
  endtask : lat
  function automatic logic [11:0] fw(input logic [2:0] f, input logic [7:0] h, l);
    case (f)
      3'h0: return {h[3:0], l};
      3'h1: return {h[4:0], l[7:1]};
      3'h2: return {h[5:0], l[7:2]};
      3'h3: return {h[6:0], l[7:3]};
      default: return {h, l[7:4]};
    endcase
  endfunction : fw
  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // ==========
  // Clock, timeout and sequence
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    void'($urandom(63436));
    ex = 12'h000;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    ax(1'b0, 8'hD4, 8'h01, 8'h00);
    `CHK(sfr_rdata, 8'h00)
    ax(1'b0, 8'hD7, 8'h01, 8'h00);
    `CHK(sfr_rdata, 8'h00)
    // Bias and buffer go on before the channel is ever enabled.
    ax(1'b1, 8'hD1, 8'h00, 8'h03);
    `CHK({bias_on, ref_buf_on, ref_pin_oe}, 3'h7)
    // Every mode is paired with every format; unused bits are random.
    for (int i = 0; i < 32; i++) begin
      r = 8'($urandom());
      r[4:0] = 5'(i);
      lo = 8'($urandom());
      hi = 8'($urandom());
      ax(1'b1, 8'hD4, 8'h01, r);
      `CHK({dac_enable, dac_out_en}, {2{r[7]}})
      ax(1'b0, 8'hD4, 8'h01, 8'h00);
      `CHK(sfr_rdata, r & 8'h9F)
      ax(1'b1, 8'hD5, 8'h01, lo);
      lat(1'b0);
      ax(1'b1, 8'hD6, 8'h01, hi);
      if (r[4:3] == 2'h0) ex = fw(r[2:0], hi, lo);
      lat(r[4:3] == 2'h0);
      ax(1'b0, 8'hD5, 8'h01, 8'h00);
      `CHK(sfr_rdata, lo)
      ax(1'b0, 8'hD6, 8'h01, 8'h00);
      `CHK(sfr_rdata, hi)
      msk = (r[4:3] == 2'h1) ? 3'h2 : (r[4:3] == 2'h2) ? 3'h1 : {r[4:3] == 2'h3, 2'h0};
      for (int k = 0; k < 3; k++) begin
        tp(3'(1 << k));
        if (msk[k]) ex = fw(r[2:0], hi, lo);
        lat(msk[k]);
      end
    end
    // The channel is shut down first, so the bias may be cleared below.
    ax(1'b1, 8'hD4, 8'h01, 8'h00);
    `CHK({dac_enable, dac_out_en}, 2'h0)
    for (int j = 0; j < 6; j++) begin
      r = (j < 2) ? 8'(j * 7) : 8'($urandom());
      ax(1'b1, 8'hD1, 8'h00, r);
      `CHK({temp_mux_sel, temp_on, bias_on, ref_buf_on, ref_pin_oe}, {r[2], r[2:0], r[0]})
      ax(1'b0, 8'hD1, 8'h00, 8'h00);
      `CHK(sfr_rdata, r & 8'h1F)
    end
    // A reset in mid-run must clear every output at once.
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK({sfr_rdata, dac_latch, dac_enable, dac_out_en, latch_strobe}, 23'h000000)
    `CHK({bias_on, ref_buf_on, ref_pin_oe, temp_on, temp_mux_sel}, 5'h00)
    @(posedge ref_clk);
    rst_n <= 1'b1;
    ax(1'b0, 8'hD4, 8'h01, 8'h00);
    `CHK(sfr_rdata, 8'h00)
    conclude();
  end
endmodule : tb_top
